// >>> rtl/scsi_resp_consts.svh
// constants of the scsi target status responder
// assumes inclusion by bare name from rtl files
`ifndef SCSI_RESP_CONSTS_SVH
`define SCSI_RESP_CONSTS_SVH
`define SENSE_LEN      18
`define SENSE_RESP     8'hf0
`define SENSE_ADDL     8'h0a
`define SB_RESP        5'h00
`define SB_KEY         5'h02
`define SB_ADDL        5'h07
`define SB_ASC         5'h0c
`define SB_ASCQ        5'h0d
`define OP_TUR         8'h00
`define OP_DIAG        8'h1d
`define OP_SETWIN      8'h24
`define CDB_SLFTST     2
`define CDB_LEN_G0     4'h6
`define CDB_LEN_G1     4'ha
`define ST_GOOD        5'h00
`define ST_CHECK       5'h01
`define MSG_COMPLETE   8'h00
`define KEY_NO_SENSE   4'h0
`define KEY_NOT_READY  4'h2
`define KEY_MEDIUM     4'h3
`define KEY_HARDWARE   4'h4
`define KEY_ILLEGAL    4'h5
`define KEY_UNIT_ATTN  4'h6
`define KEY_ABORTED    4'hb
`define ASC_NONE       8'h00
`define ASC_MEDIUM     8'h80
`define ASC_INTERNAL   8'h44
`define ASC_PARITY     8'h47
`define ASC_BAD_CMD    8'h20
`define ASC_BAD_CDB    8'h24
`define ASC_BAD_LUN    8'h25
`define ASC_BAD_PARAM  8'h26
`define ASC_MSG_ERR    8'h43
`define ASCQ_NONE      8'h00
`define ASCQ_JAM       8'h01
`define ASCQ_COVER     8'h02
`define ASCQ_CHUTE     8'h03
`endif

// >>> rtl/scsi_resp_pkg.sv
// types of the scsi target status responder
// assumes nothing of its surroundings
package scsi_resp_pkg;
  typedef enum logic [3:0] {
    cause_none, cause_not_ready, cause_jam, cause_cover, cause_chute,
    cause_internal, cause_parity, cause_bad_cmd, cause_bad_cdb,
    cause_bad_lun, cause_bad_param, cause_unit_attn, cause_msg_err
  } cause_type;
  typedef enum logic [2:0] {
    ph_free, ph_msg_out, ph_command, ph_data_out, ph_status, ph_msg_in
  } phase_type;
  typedef enum logic [2:0] {
    st_idle, st_msg_out, st_command, st_exec, st_data_out, st_status,
    st_msg_in
  } state_type;
endpackage

// >>> rtl/scsi_status_responder.sv
// scsi target command responder: phases, status and sense data
// assumes byte handshakes from the initiator synchronous to ref_clk
`include "scsi_resp_consts.svh"
// Summary of operation
// - command-specific information bytes 8 to b always read zero
// - additional sense code in byte c, qualifier in byte d
// - medium errors use code 80, qualifier 01 jam, 02 cover, 03 chute
// - illegal request uses codes 20, 24, 25, 26 with qualifier 00
// - 44 internal, 47 parity, 43 message, 00 otherwise, qualifier 00
// - self-test: select, lun message, command, status, complete
// - only the internal self-test form is supported
// - page format and offline bits of byte 1 are ignored
// - parameter list length field is not acted upon
// - self-test is a no-op but reports check when error is pending
// - passing self-test returns good status and leaves the sense record untouched
// - pending error at self-test gives check and that sense key
// - readiness query: command, status, complete, no data phase
// - ready unit answers readiness query with good, sense record untouched
// - unready unit answers with check condition, key 2
// - set window: command, data out, status, complete message
// - busy held from selection until command complete is sent
// - sense byte 0 carries valid bit and response code 70
// - sense is built on check condition, after bus-free error or on a unit error (err_valid)
module scsi_status_responder #(
  parameter int XFER_W = 24
) (
  // clock, reset, enable
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // initiator side
  input  wire logic                     sel,
  input  wire logic                     atn,
  input  wire logic                     in_strobe,
  input  wire logic [7:0]               in_byte,
  input  wire logic                     out_ack,
  output logic                          bsy_reg,
  output logic                          req_reg,
  output scsi_resp_pkg::phase_type      phase_reg,
  output logic [7:0]                    out_byte_reg,
  // unit state and errors
  input  wire logic                     lun_ready,
  input  wire logic                     err_valid,
  input  wire scsi_resp_pkg::cause_type err_cause,
  input  wire logic                     busfree_err,
  input  wire scsi_resp_pkg::cause_type busfree_cause,
  // window data out
  output logic                          win_valid_reg,
  output logic [7:0]                    win_byte_reg,
  // sense readout
  input  wire logic [4:0]               sense_raddr,
  input  wire logic                     sense_taken,
  output logic [7:0]                    sense_rdata,
  output logic                          sense_busy_reg,
  output logic                          pend_reg
);
  import scsi_resp_pkg::*;

  sense_port_if sp ();

  state_type         state_reg;
  logic [7:0]        op_reg;
  logic [7:0]        cdb1_reg;
  logic [XFER_W-1:0] xfer_reg;
  logic [3:0]        cnt_reg;
  logic              lun_bad_reg;
  logic              chk_reg;
  cause_type         exec_cause;
  cause_type         pend_cause_reg;
  logic [3:0]        cdb_len;
  logic              take_in;
  logic              take_out;
  logic              build_start;
  cause_type         build_cause;
  cause_type         cause_reg;
  logic [4:0]        wr_cnt_reg;
  logic [3:0]        map_key;
  logic [7:0]        map_asc;
  logic [7:0]        map_ascq;

  assign take_in  = req_reg && in_strobe;
  assign take_out = req_reg && out_ack;
  assign cdb_len  = (op_reg[7:5] == 3'b000) ? `CDB_LEN_G0 : `CDB_LEN_G1;

  // outcome of the command just received
  always_comb
  begin
    exec_cause = cause_none;
    if (lun_bad_reg)
      exec_cause = cause_bad_lun;
    else
    begin
      case (op_reg)
        `OP_TUR:
          if (!lun_ready)
            exec_cause = cause_not_ready;
        `OP_DIAG:
          if (!cdb1_reg[`CDB_SLFTST])
            exec_cause = cause_bad_cdb;
          else if (pend_reg)
            exec_cause = pend_cause_reg;
        `OP_SETWIN:
          exec_cause = cause_none;
        default:
          exec_cause = cause_bad_cmd;
      endcase
    end
  end

  // phase sequencer
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg     <= st_idle;
      phase_reg     <= ph_free;
      bsy_reg       <= 1'b0;
      req_reg       <= 1'b0;
      out_byte_reg  <= 8'h00;
      op_reg        <= 8'h00;
      cdb1_reg      <= 8'h00;
      xfer_reg      <= '0;
      cnt_reg       <= 4'h0;
      lun_bad_reg   <= 1'b0;
      chk_reg       <= 1'b0;
      win_valid_reg <= 1'b0;
      win_byte_reg  <= 8'h00;
    end
    else if (ce)
    begin
      win_valid_reg <= 1'b0;
      unique case (state_reg)
        st_idle:
          if (sel)
          begin
            bsy_reg     <= 1'b1;
            lun_bad_reg <= 1'b0;
            cnt_reg     <= 4'h0;
            state_reg   <= atn ? st_msg_out : st_command;
            phase_reg   <= atn ? ph_msg_out : ph_command;
          end
        st_msg_out:
          if (!req_reg)
            req_reg <= 1'b1;
          else if (take_in)
          begin
            req_reg     <= 1'b0;
            lun_bad_reg <= (in_byte[2:0] != 3'b000);
            state_reg   <= st_command;
            phase_reg   <= ph_command;
          end
        st_command:
          if (!req_reg)
            req_reg <= 1'b1;
          else if (take_in)
          begin
            req_reg <= 1'b0;
            cnt_reg <= cnt_reg + 4'h1;
            // bytes 3 and 4 (parameter length) are never looked at
            unique case (cnt_reg)
              4'h0: op_reg <= in_byte;
              4'h1: cdb1_reg <= in_byte;
              4'h6: xfer_reg[23:16] <= in_byte;
              4'h7: xfer_reg[15:8] <= in_byte;
              4'h8: xfer_reg[7:0] <= in_byte;
              default: ;
            endcase
            if ((cnt_reg + 4'h1 == `CDB_LEN_G0 && in_byte[7:5] == 3'b000
                 && cnt_reg == 4'h0)
                || (cnt_reg != 4'h0 && cnt_reg + 4'h1 == cdb_len))
              state_reg <= st_exec;
          end
        st_exec:
        begin
          chk_reg <= (exec_cause != cause_none);
          if (exec_cause == cause_none && op_reg == `OP_SETWIN
              && xfer_reg != '0)
          begin
            state_reg <= st_data_out;
            phase_reg <= ph_data_out;
          end
          else
          begin
            state_reg <= st_status;
            phase_reg <= ph_status;
          end
        end
        st_data_out:
          if (!req_reg)
            req_reg <= 1'b1;
          else if (take_in)
          begin
            req_reg       <= 1'b0;
            win_valid_reg <= 1'b1;
            win_byte_reg  <= in_byte;
            xfer_reg      <= xfer_reg - XFER_W'(1);
            if (xfer_reg == XFER_W'(1))
            begin
              state_reg <= st_status;
              phase_reg <= ph_status;
            end
          end
        st_status:
          if (!req_reg)
          begin
            req_reg      <= 1'b1;
            out_byte_reg <= {2'b00, chk_reg ? `ST_CHECK : `ST_GOOD, 1'b0};
          end
          else if (take_out)
          begin
            req_reg   <= 1'b0;
            state_reg <= st_msg_in;
            phase_reg <= ph_msg_in;
          end
        st_msg_in:
          if (!req_reg)
          begin
            req_reg      <= 1'b1;
            out_byte_reg <= `MSG_COMPLETE;
          end
          else if (take_out)
          begin
            req_reg   <= 1'b0;
            bsy_reg   <= 1'b0;
            state_reg <= st_idle;
            phase_reg <= ph_free;
          end
      endcase
    end
  end

  // which error, if any, rewrites the sense record
  always_comb
  begin
    build_start = 1'b0;
    build_cause = cause_none;
    if (ce && state_reg == st_exec && exec_cause != cause_none)
    begin
      build_start = 1'b1;
      build_cause = exec_cause;
    end
    else if (ce && busfree_err)
    begin
      build_start = 1'b1;
      build_cause = busfree_cause;
    end
    else if (ce && err_valid)
    begin
      build_start = 1'b1;
      build_cause = err_cause;
    end
  end

  // held error: a new error wins over retrieval in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pend_reg       <= 1'b0;
      pend_cause_reg <= cause_none;
    end
    else if (ce)
    begin
      if (err_valid)
      begin
        pend_reg       <= 1'b1;
        pend_cause_reg <= err_cause;
      end
      else if (sense_taken)
        pend_reg <= 1'b0;
    end
  end

  // sense writer walks the record one byte a cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sense_busy_reg <= 1'b0;
      wr_cnt_reg     <= 5'h00;
      cause_reg      <= cause_none;
    end
    else if (ce)
    begin
      if (build_start)
      begin
        sense_busy_reg <= 1'b1;
        wr_cnt_reg     <= 5'h00;
        cause_reg      <= build_cause;
      end
      else if (sense_busy_reg)
      begin
        wr_cnt_reg <= wr_cnt_reg + 5'h01;
        if (wr_cnt_reg == 5'(`SENSE_LEN - 1))
          sense_busy_reg <= 1'b0;
      end
    end
  end

  sense_code_map u_map (
    .cause (cause_reg),
    .key   (map_key),
    .asc   (map_asc),
    .ascq  (map_ascq)
  );

  // sense byte contents; unlisted bytes, f to 11 among them, hold zero
  always_comb
  begin
    sp.ce    = ce;
    sp.we    = sense_busy_reg;
    sp.waddr = wr_cnt_reg;
    sp.raddr = sense_raddr;
    unique case (wr_cnt_reg)
      `SB_RESP: sp.wdata = `SENSE_RESP;
      `SB_KEY:  sp.wdata = {4'h0, map_key};
      `SB_ADDL: sp.wdata = `SENSE_ADDL;
      `SB_ASC:  sp.wdata = map_asc;
      `SB_ASCQ: sp.wdata = map_ascq;
      default:  sp.wdata = 8'h00;
    endcase
  end

  sense_store #(
    .DEPTH (`SENSE_LEN)
  ) u_store (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sp      (sp.store)
  );

  assign sense_rdata = sp.rdata;
endmodule

// >>> rtl/sense_code_map.sv
// maps an error cause onto sense key, code and qualifier
// assumes a purely combinational use
`include "scsi_resp_consts.svh"
module sense_code_map (
  // cause in
  input  wire scsi_resp_pkg::cause_type cause,
  // sense fields out
  output logic [3:0]                    key,
  output logic [7:0]                    asc,
  output logic [7:0]                    ascq
);
  import scsi_resp_pkg::*;

  always_comb
  begin
    key  = `KEY_NO_SENSE;
    asc  = `ASC_NONE;
    ascq = `ASCQ_NONE;
    unique case (cause)
      cause_none      : key = `KEY_NO_SENSE;
      cause_not_ready : key = `KEY_NOT_READY;
      cause_jam       :
      begin
        key  = `KEY_MEDIUM;
        asc  = `ASC_MEDIUM;
        ascq = `ASCQ_JAM;
      end
      cause_cover     :
      begin
        key  = `KEY_MEDIUM;
        asc  = `ASC_MEDIUM;
        ascq = `ASCQ_COVER;
      end
      cause_chute     :
      begin
        key  = `KEY_MEDIUM;
        asc  = `ASC_MEDIUM;
        ascq = `ASCQ_CHUTE;
      end
      cause_internal  :
      begin
        key = `KEY_HARDWARE;
        asc = `ASC_INTERNAL;
      end
      cause_parity    :
      begin
        key = `KEY_HARDWARE;
        asc = `ASC_PARITY;
      end
      cause_bad_cmd   :
      begin
        key = `KEY_ILLEGAL;
        asc = `ASC_BAD_CMD;
      end
      cause_bad_cdb   :
      begin
        key = `KEY_ILLEGAL;
        asc = `ASC_BAD_CDB;
      end
      cause_bad_lun   :
      begin
        key = `KEY_ILLEGAL;
        asc = `ASC_BAD_LUN;
      end
      cause_bad_param :
      begin
        key = `KEY_ILLEGAL;
        asc = `ASC_BAD_PARAM;
      end
      cause_unit_attn : key = `KEY_UNIT_ATTN;
      cause_msg_err   :
      begin
        key = `KEY_ABORTED;
        asc = `ASC_MSG_ERR;
      end
      default         : key = `KEY_NO_SENSE;
    endcase
  end
endmodule

// >>> rtl/sense_port_if.sv
// byte port between the responder and its sense store
// assumes one clock shared by both ends
interface sense_port_if;
  logic       ce;
  logic       we;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic [4:0] raddr;
  logic [7:0] rdata;
  modport writer (output ce, output we, output waddr, output wdata,
                  output raddr, input rdata);
  modport store  (input ce, input we, input waddr, input wdata,
                  input raddr, output rdata);
endinterface

// >>> rtl/sense_store.sv
// eighteen byte sense record with registered read data
// assumes writer holds addresses inside the record
module sense_store #(
  parameter int DEPTH = 18
) (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // byte port
  sense_port_if.store sp
);
  logic [7:0] mem_reg [DEPTH];

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= 8'h00;
    end
    else if (sp.ce && sp.we && (int'(sp.waddr) < DEPTH))
      mem_reg[sp.waddr] <= sp.wdata;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sp.rdata <= 8'h00;
    else if (sp.ce)
      sp.rdata <= (int'(sp.raddr) < DEPTH) ? mem_reg[sp.raddr] : 8'h00;
  end
endmodule

// >>> tb/initiator_model.sv
// initiator model: selects, sends bytes, takes status and message
// assumes target handshakes sampled on rising ref_clk
module initiator_model (
  // clock
  input  wire logic                     ref_clk,
  // target outputs
  input  wire logic                     req_reg,
  input  wire scsi_resp_pkg::phase_type phase_reg,
  input  wire logic [7:0]               out_byte_reg,
  // initiator drives
  output logic                          sel,
  output logic                          atn,
  output logic                          in_strobe,
  output logic [7:0]                    in_byte,
  output logic                          out_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  import scsi_resp_pkg::*;
  initial
  begin
    sel = 1'b0;
    atn = 1'b0;
    in_strobe = 1'b0;
    in_byte = 8'h5a;
    out_ack = 1'b0;
  end
  task automatic put(input logic [7:0] b);
    @(posedge ref_clk);
    in_strobe <= 1'b1;
    in_byte <= b;
    do @(posedge ref_clk); while (!req_reg);
    in_strobe <= 1'b0;
    in_byte <= ~b;
  endtask
  task automatic get(output logic [7:0] b, output phase_type p);
    @(posedge ref_clk);
    out_ack <= 1'b1;
    do @(posedge ref_clk); while (!req_reg);
    b = out_byte_reg;
    p = phase_reg;
    out_ack <= 1'b0;
  endtask
  task automatic run(input logic a, input logic [7:0] lun,
    input logic [79:0] c, input int n, input int nd,
    output logic [7:0] st, output phase_type sp,
    output logic [7:0] ms, output phase_type mp);
    @(posedge ref_clk);
    sel <= 1'b1;
    atn <= a;
    @(posedge ref_clk);
    sel <= 1'b0;
    atn <= 1'b0;
    if (a) put(lun);
    for (int i = 0; i < n; i++) put(c[79-8*i -: 8]);
    for (int i = 0; i < nd; i++) put(8'(i) ^ 8'h5a);
    get(st, sp);
    get(ms, mp);
  endtask
endmodule

// >>> tb/scsi_resp_chk.sv
// checker of busy, phases, status bytes and pending flag
// assumes binding onto scsi_status_responder with one clock
module scsi_resp_chk (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst,
  input wire logic                     ce,
  // initiator side
  input wire logic                     sel,
  input wire logic                     in_strobe,
  input wire logic                     out_ack,
  input wire logic                     bsy_reg,
  input wire logic                     req_reg,
  input wire scsi_resp_pkg::phase_type phase_reg,
  input wire logic [7:0]               out_byte_reg,
  // errors and window data
  input wire logic                     err_valid,
  input wire logic                     sense_taken,
  input wire logic                     win_valid_reg,
  input wire logic                     pend_reg
);
  import scsi_resp_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_req_in_bsy: assert property (req_reg |-> bsy_reg)
    else $error("request while not busy");
  a_sel_bsy: assert property (ce && sel && !bsy_reg &&
    phase_reg == ph_free |=> bsy_reg)
    else $error("busy missing after selection");
  a_bsy_holds: assert property (bsy_reg && !(ce && req_reg &&
    out_ack && phase_reg == ph_msg_in) |=> bsy_reg)
    else $error("busy dropped early");
  a_free_after_cc: assert property (ce && req_reg && out_ack &&
    phase_reg == ph_msg_in |=> !bsy_reg && phase_reg == ph_free)
    else $error("bus not freed after complete");
  a_msg_byte: assert property (req_reg &&
    phase_reg == ph_msg_in |-> out_byte_reg == 8'h00)
    else $error("message byte not complete");
  a_status_byte: assert property (req_reg &&
    phase_reg == ph_status |-> out_byte_reg inside {8'h00, 8'h02})
    else $error("bad status byte");
  a_status_next: assert property (ce && req_reg && out_ack &&
    phase_reg == ph_status |=> phase_reg == ph_msg_in)
    else $error("no message phase after status");
  a_byte_taken: assert property (ce && req_reg && in_strobe &&
    phase_reg inside {ph_msg_out, ph_command, ph_data_out}
    |=> !req_reg)
    else $error("request kept after byte");
  a_win_cause: assert property (win_valid_reg && $past(ce) |->
    $past(req_reg) && $past(in_strobe) &&
    $past(phase_reg) == ph_data_out)
    else $error("window byte without data out");
  a_pend_set: assert property (ce && err_valid |=> pend_reg)
    else $error("error not pending");
  a_pend_clear: assert property (ce && sense_taken &&
    !err_valid |=> !pend_reg)
    else $error("pending not cleared");
endmodule

bind scsi_status_responder scsi_resp_chk chk (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .sel(sel),
  .in_strobe(in_strobe), .out_ack(out_ack), .bsy_reg(bsy_reg),
  .req_reg(req_reg), .phase_reg(phase_reg),
  .out_byte_reg(out_byte_reg), .err_valid(err_valid),
  .sense_taken(sense_taken), .win_valid_reg(win_valid_reg),
  .pend_reg(pend_reg)
);

// >>> tb/test_scsi_status_responder.sv
// testbench of the scsi target status responder
// assumes initiator_model and the bound checker
module test_scsi_status_responder;
  timeunit 1ns;
  timeprecision 1ns;
  import scsi_resp_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic       sel, atn, in_strobe, out_ack, bsy_reg, req_reg;
  logic [7:0] in_byte, out_byte_reg, win_byte_reg, sense_rdata;
  logic       win_valid_reg, sense_busy_reg, pend_reg;
  phase_type  phase_reg, sp, mp;
  logic [7:0] st, ms;
  logic       lun_ready = 1'b1;
  logic       err_valid = 1'b0;
  logic       busfree_err = 1'b0;
  cause_type  err_cause = cause_none;
  cause_type  busfree_cause = cause_none;
  logic [4:0] sense_raddr = 5'h00;
  logic       sense_taken = 1'b0;
  int         err_total = 0;
  int         num_checks = 0;
  int         wins = 0;
  logic [19:0] tbl[13] = '{20'h00000, 20'h20000, 20'h38001, 20'h38002,
    20'h38003, 20'h44400, 20'h44700, 20'h52000, 20'h52400, 20'h52500,
    20'h52600, 20'h60000, 20'hb4300};
  always #10 ref_clk = ~ref_clk;
  scsi_status_responder dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .sel(sel), .atn(atn),
    .in_strobe(in_strobe), .in_byte(in_byte), .out_ack(out_ack),
    .bsy_reg(bsy_reg), .req_reg(req_reg), .phase_reg(phase_reg),
    .out_byte_reg(out_byte_reg), .lun_ready(lun_ready),
    .err_valid(err_valid), .err_cause(err_cause),
    .busfree_err(busfree_err), .busfree_cause(busfree_cause),
    .win_valid_reg(win_valid_reg), .win_byte_reg(win_byte_reg),
    .sense_raddr(sense_raddr), .sense_taken(sense_taken),
    .sense_rdata(sense_rdata), .sense_busy_reg(sense_busy_reg),
    .pend_reg(pend_reg)
  );
  initiator_model ini (
    .ref_clk(ref_clk), .req_reg(req_reg), .phase_reg(phase_reg),
    .out_byte_reg(out_byte_reg), .sel(sel), .atn(atn),
    .in_strobe(in_strobe), .in_byte(in_byte), .out_ack(out_ack)
  );
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic fault(input logic bf, input cause_type c);
    @(posedge ref_clk);
    err_valid <= !bf;
    err_cause <= c;
    busfree_err <= bf;
    busfree_cause <= c;
    @(posedge ref_clk);
    err_valid <= 1'b0;
    busfree_err <= 1'b0;
    @(posedge ref_clk);
    cmp({7'h00, sense_busy_reg}, {7'h00, ce});
    repeat (21) @(posedge ref_clk);
    cmp({7'h00, sense_busy_reg}, 8'h00);
  endtask
  task automatic sense(input logic [3:0] k, input logic [7:0] c,
    input logic [7:0] q);
    logic [4:0] ad[9];
    logic [7:0] ex[9];
    ad = '{5'h00, 5'h02, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d};
    ex = '{8'hf0, {4'h0, k}, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, c, q};
    for (int i = 0; i < 9; i++)
    begin
      @(posedge ref_clk);
      sense_raddr <= ad[i];
      repeat (2) @(posedge ref_clk);
      cmp(sense_rdata, ex[i]);
    end
  endtask
  task automatic cmd(input logic a, input logic [79:0] c, input int n,
    input int nd, input logic [7:0] es);
    ini.run(a, 8'h80, c, n, nd, st, sp, ms, mp);
    cmp(st, es);
    cmp({5'h00, sp}, {5'h00, ph_status});
    cmp(ms, 8'h00);
    cmp({5'h00, mp}, {5'h00, ph_msg_in});
    repeat (2) @(posedge ref_clk);
    cmp({7'h00, bsy_reg}, 8'h00);
  endtask
  always @(posedge ref_clk)
    if (win_valid_reg === 1'b1)
    begin
      cmp(win_byte_reg, 8'(wins) ^ 8'h5a);
      wins++;
    end
  initial
  begin
    repeat (6000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++)
    begin
      fault(1'b1, cause_type'(i[3:0]));
      sense(tbl[i][19:16], tbl[i][15:8],
        tbl[i][7:0]);
    end
    $display("test sense codes done");
    cmd(1'b0, 80'h0, 6, 0, 8'h00);
    sense(4'hb, 8'h43, 8'h00);
    @(posedge ref_clk);
    lun_ready <= 1'b0;
    cmd(1'b1, 80'h0, 6, 0, 8'h02);
    sense(4'h2, 8'h00, 8'h00);
    lun_ready <= 1'b1;
    cmd(1'b0, 80'h12000000000000000000, 6, 0, 8'h02);
    sense(4'h5, 8'h20, 8'h00);
    $display("test ready query done");
    fault(1'b0, cause_jam);
    cmp({7'h00, pend_reg}, 8'h01);
    cmd(1'b1, 80'h1d170012340000000000, 6, 0, 8'h02);
    sense(4'h3, 8'h80, 8'h01);
    @(posedge ref_clk);
    sense_taken <= 1'b1;
    @(posedge ref_clk);
    sense_taken <= 1'b0;
    @(posedge ref_clk);
    cmp({7'h00, pend_reg}, 8'h00);
    ce <= 1'b0;
    fault(1'b0, cause_chute);
    cmp({7'h00, pend_reg}, 8'h00);
    ce <= 1'b1;
    sense(4'h3, 8'h80, 8'h01);
    cmd(1'b1, 80'h1d040000000000000000, 6, 0, 8'h00);
    cmd(1'b1, 80'h1d100000000000000000, 6, 0, 8'h02);
    sense(4'h5, 8'h24, 8'h00);
    cmp(8'(wins), 8'h00);
    $display("test self test done");
    cmd(1'b0, 80'h24000000000000000300, 10, 3, 8'h00);
    cmp(8'(wins), 8'h03);
    $display("test set window done");
    wrap_up();
  end
endmodule
